// [verilog/alc_top.sv]
// Purpose: Control/status and data registers of the antenna control link, plus
//          the sequencing that starts, ends and reports link transactions
// Assumes: Register port already decoded to byte address, one access per strobe
// Notes: Outbound data leaves on the main pin; inbound comes from the main pin in
//        one-pin wiring or from the shared general pin in two-pin wiring
//
// Overview of operation
// - A fault seen while receiving from the antenna sets the receive fault flag in bit 5.
// - The receive fault flag is cleared when the next antenna transaction starts.
// - With auto-receive set, the block readies a receive once a transmit ends.
// - The host starts a transaction by writing 1 to send-go and the block clears it at the end.
// - Direction-select 0 picks a receive transaction and 1 picks a transmit transaction.
// - In auto-receive the block writes direction-select to 0 after the transmit ends.
// - Polarity bit 1 inverts the outbound line, 0 keeps normal polarity.
// - Pin-count 0 uses separate in and out pins, 1 uses one two-way pin.
// - The 14-bit outbound word sits in offset 60h bits 7:0 and 61h bits 5:0.
// - The 10-bit received code sits in offset 62h bits 7:0 and 63h bits 1:0.
`timescale 1ns/10ps
module alc_top
(
   input wire logic clock,
   input wire logic srst,
   input alc_pkg::alc_reg_req_type reg_req,
   output logic [7:0] reg_rdata,
   input wire logic link_pin_i,
   output logic link_pin_o,
   output logic link_pin_oe,
   input wire logic shared_general_pin_i,
   output logic link_busy
);
   import alc_pkg::*;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      alc_phase_type phase;
      alc_ctrl_type ctrl;
      logic [TX_WORD_W-1:0] tx_word;
      logic [RX_CODE_W-1:0] rx_code;
      logic [7:0] rdata;
      logic start_tx;
      logic start_rx;
      logic busy;
   } alc_state_type;

   alc_state_type st_q;
   alc_state_type st_d;

   alc_pin_out_type eng_pin;
   logic eng_done;
   logic eng_fault;
   logic [RX_CODE_W-1:0] eng_code;
   logic rx_line;

   // Two-pin wiring listens on the shared general pin; the host has made it an
   // input beforehand, so it is taken here as a plain input
   assign rx_line = st_q.ctrl.pin_count_select ? link_pin_i : shared_general_pin_i;

   // ----------------------------------------------------------------------
   // Line engine
   // ----------------------------------------------------------------------
   alc_link_engine u_engine
   (
      .clock(clock),
      .srst(srst),
      .start_tx(st_q.start_tx),
      .start_rx(st_q.start_rx),
      .word(st_q.tx_word),
      .invert(st_q.ctrl.send_polarity_invert),
      .one_pin(st_q.ctrl.pin_count_select),
      .rx_line(rx_line),
      .pin(eng_pin),
      .done(eng_done),
      .fault(eng_fault),
      .code(eng_code)
   );

   // ----------------------------------------------------------------------
   // Register writes and transaction sequencing
   // ----------------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      st_d.start_tx = 1'b0;
      st_d.start_rx = 1'b0;

      // Host writes first, so that the block's own updates below win
      if (reg_req.wr)
      begin
         case (reg_req.addr)
            ADDR_CTRL:
            begin
               st_d.ctrl.pin_count_select = reg_req.wdata[BIT_PIN_COUNT];
               st_d.ctrl.send_polarity_invert = reg_req.wdata[BIT_POLARITY];
               st_d.ctrl.direction_select = reg_req.wdata[BIT_DIRECTION];
               st_d.ctrl.auto_receive = reg_req.wdata[BIT_AUTO_RX];
               st_d.ctrl.rx_fault_flag = reg_req.wdata[BIT_RX_FAULT];
               st_d.ctrl.spare = reg_req.wdata[BIT_SPARE];
               // Writing 0 to send-go does not abort a running transaction
               if (reg_req.wdata[BIT_SEND_GO])
                  st_d.ctrl.send_go = 1'b1;
            end
            ADDR_TXD_LO:
               st_d.tx_word[7:0] = reg_req.wdata;
            ADDR_TXD_HI:
               st_d.tx_word[TX_WORD_W-1:8] = reg_req.wdata[TX_HI_W-1:0];
            ADDR_RXD_LO:
               st_d.rx_code[7:0] = reg_req.wdata;
            ADDR_RXD_HI:
               st_d.rx_code[RX_CODE_W-1:8] = reg_req.wdata[RX_HI_W-1:0];
            default:
               st_d.rx_code = st_q.rx_code;
         endcase
      end

      case (st_q.phase)
         P_IDLE:
         begin
            if (st_q.ctrl.send_go)
            begin
               st_d.busy = 1'b1;
               st_d.ctrl.rx_fault_flag = 1'b0;
               if (st_q.ctrl.direction_select)
               begin
                  st_d.phase = P_TX;
                  st_d.start_tx = 1'b1;
               end
               else
               begin
                  st_d.phase = P_RX;
                  st_d.start_rx = 1'b1;
               end
            end
         end
         P_TX:
         begin
            if (eng_done)
            begin
               st_d.phase = P_IDLE;
               st_d.busy = 1'b0;
               st_d.ctrl.send_go = 1'b0;
               // Auto-receive readies the next transaction as a receive
               if (st_q.ctrl.auto_receive)
                  st_d.ctrl.direction_select = 1'b0;
            end
         end
         P_RX:
         begin
            if (eng_done)
            begin
               st_d.phase = P_IDLE;
               st_d.busy = 1'b0;
               st_d.ctrl.send_go = 1'b0;
               if (eng_fault)
                  st_d.ctrl.rx_fault_flag = 1'b1;
               else
                  st_d.rx_code = eng_code;
            end
         end
         default:
            st_d.phase = P_IDLE;
      endcase

      // ----------------------------------------------------------------------
      // Read data, registered
      // ----------------------------------------------------------------------
      if (reg_req.rd)
      begin
         case (reg_req.addr)
            ADDR_CTRL:
               st_d.rdata = {1'b0, st_q.ctrl};
            ADDR_TXD_LO:
               st_d.rdata = st_q.tx_word[7:0];
            ADDR_TXD_HI:
               st_d.rdata = {2'b00, st_q.tx_word[TX_WORD_W-1:8]};
            ADDR_RXD_LO:
               st_d.rdata = st_q.rx_code[7:0];
            ADDR_RXD_HI:
               st_d.rdata = {6'b000000, st_q.rx_code[RX_CODE_W-1:8]};
            default:
               st_d.rdata = READ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         st_q <= '0;
         st_q.phase <= P_IDLE;
         st_q.rdata <= RESET_BYTE;
      end
      else
         st_q <= st_d;
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign reg_rdata = st_q.rdata;
   assign link_pin_o = eng_pin.line_o;
   assign link_pin_oe = eng_pin.line_oe;
   assign link_busy = st_q.busy;

endmodule

// [verilog/alc_pkg.sv]
// Purpose: Shared constants and types for the antenna link control block
// Assumes: 8-bit register port, 25 MHz clock
// Notes: Line timing is not fixed by the register map; the figures here are plain defaults
package alc_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h5f;
   localparam logic [7:0] ADDR_TXD_LO = 8'h60;
   localparam logic [7:0] ADDR_TXD_HI = 8'h61;
   localparam logic [7:0] ADDR_RXD_LO = 8'h62;
   localparam logic [7:0] ADDR_RXD_HI = 8'h63;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Control/status field positions
   localparam int BIT_PIN_COUNT = 0;
   localparam int BIT_POLARITY = 1;
   localparam int BIT_DIRECTION = 2;
   localparam int BIT_SEND_GO = 3;
   localparam int BIT_AUTO_RX = 4;
   localparam int BIT_RX_FAULT = 5;
   localparam int BIT_SPARE = 6;

   localparam int TX_WORD_W = 14;
   localparam int RX_CODE_W = 10;
   localparam int TX_HI_W = 6;
   localparam int RX_HI_W = 2;

   // ----------------------------------------------------------------------
   // Line timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int LINK_BIT_NS = 1000;
   localparam int LINK_RX_WAIT_NS = 100000;
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] BIT_CYC =
      CNT_W'((LINK_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] FIRST_SAMPLE_CYC = CNT_W'(BIT_CYC + BIT_CYC / 2);
   localparam logic [CNT_W-1:0] RX_WAIT_CYC = CNT_W'(LINK_RX_WAIT_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

   // Frame: start bit, 14 data bits LSB first, stop bit
   localparam int TX_FRAME_W = TX_WORD_W + 2;
   localparam logic [4:0] TX_LAST_IDX = 5'(TX_FRAME_W - 1);
   // Receive: 10 data bits then one stop bit
   localparam logic [4:0] RX_STOP_IDX = 5'(RX_CODE_W);
   localparam logic [4:0] IDX_ZERO = 5'h00;
   localparam logic [4:0] IDX_ONE = 5'h01;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } alc_reg_req_type;

   typedef struct packed {
      logic spare;
      logic rx_fault_flag;
      logic auto_receive;
      logic send_go;
      logic direction_select;
      logic send_polarity_invert;
      logic pin_count_select;
   } alc_ctrl_type;

   typedef struct packed {
      logic line_o;
      logic line_oe;
   } alc_pin_out_type;

   typedef enum logic [1:0] {E_IDLE, E_TX, E_RX_WAIT, E_RX_BITS} alc_eng_phase_type;
   typedef enum logic [1:0] {P_IDLE, P_TX, P_RX} alc_phase_type;

endpackage

// [verilog/alc_link_engine.sv]
// Purpose: Bit engine that sends the outbound word and captures the program code
// Assumes: Line input synchronous to clock; one start/stop framed bit stream
// Notes: Only the outbound line is inverted by the polarity bit
`timescale 1ns/10ps
module alc_link_engine
(
   input wire logic clock,
   input wire logic srst,
   input wire logic start_tx,
   input wire logic start_rx,
   input wire logic [alc_pkg::TX_WORD_W-1:0] word,
   input wire logic invert,
   input wire logic one_pin,
   input wire logic rx_line,
   output alc_pkg::alc_pin_out_type pin,
   output logic done,
   output logic fault,
   output logic [alc_pkg::RX_CODE_W-1:0] code
);
   import alc_pkg::*;

   typedef struct packed {
      alc_eng_phase_type phase;
      logic [CNT_W-1:0] cnt;
      logic [4:0] idx;
      logic [TX_FRAME_W-1:0] shreg;
      alc_pin_out_type pin;
      logic done;
      logic fault;
      logic [RX_CODE_W-1:0] code;
   } alc_eng_state_type;

   alc_eng_state_type st_q;
   alc_eng_state_type st_d;

   always_comb
   begin
      st_d = st_q;
      st_d.done = 1'b0;
      case (st_q.phase)
         E_IDLE:
         begin
            st_d.pin.line_o = ~invert;
            st_d.pin.line_oe = ~one_pin;
            if (start_tx)
            begin
               st_d.phase = E_TX;
               st_d.shreg = {1'b1, word, 1'b0};
               st_d.idx = IDX_ZERO;
               st_d.cnt = BIT_CYC - CNT_ONE;
               st_d.pin.line_o = invert;
               st_d.pin.line_oe = 1'b1;
            end
            else if (start_rx)
            begin
               st_d.phase = E_RX_WAIT;
               st_d.cnt = RX_WAIT_CYC - CNT_ONE;
               st_d.fault = 1'b0;
            end
         end
         E_TX:
         begin
            if (st_q.cnt != CNT_ZERO)
               st_d.cnt = st_q.cnt - CNT_ONE;
            else if (st_q.idx == TX_LAST_IDX)
            begin
               st_d.phase = E_IDLE;
               st_d.done = 1'b1;
               st_d.fault = 1'b0;
               st_d.pin.line_o = ~invert;
               st_d.pin.line_oe = ~one_pin;
            end
            else
            begin
               st_d.cnt = BIT_CYC - CNT_ONE;
               st_d.idx = st_q.idx + IDX_ONE;
               st_d.shreg = {1'b0, st_q.shreg[TX_FRAME_W-1:1]};
               st_d.pin.line_o = st_q.shreg[1] ^ invert;
            end
         end
         E_RX_WAIT:
         begin
            if (!rx_line)
            begin
               st_d.phase = E_RX_BITS;
               st_d.cnt = FIRST_SAMPLE_CYC - CNT_ONE;
               st_d.idx = IDX_ZERO;
            end
            else if (st_q.cnt == CNT_ZERO)
            begin
               // No answer from the antenna counts as a receive fault
               st_d.phase = E_IDLE;
               st_d.done = 1'b1;
               st_d.fault = 1'b1;
            end
            else
               st_d.cnt = st_q.cnt - CNT_ONE;
         end
         E_RX_BITS:
         begin
            if (st_q.cnt != CNT_ZERO)
               st_d.cnt = st_q.cnt - CNT_ONE;
            else if (st_q.idx == RX_STOP_IDX)
            begin
               st_d.phase = E_IDLE;
               st_d.done = 1'b1;
               st_d.fault = ~rx_line;
            end
            else
            begin
               st_d.cnt = BIT_CYC - CNT_ONE;
               st_d.idx = st_q.idx + IDX_ONE;
               st_d.code = {rx_line, st_q.code[RX_CODE_W-1:1]};
            end
         end
         default:
            st_d.phase = E_IDLE;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         st_q <= '0;
         st_q.phase <= E_IDLE;
         st_q.pin.line_o <= 1'b1;
         st_q.pin.line_oe <= 1'b1;
      end
      else
         st_q <= st_d;
   end

   assign pin = st_q.pin;
   assign done = st_q.done;
   assign fault = st_q.fault;
   assign code = st_q.code;

endmodule

// [verification/alc_top_sva.sv]
// Purpose: Port checks for the antenna link control block
// Assumes: Host leaves the configuration alone while a transaction runs
// Notes: Control bits are shadowed from host writes
`timescale 1ns/10ps
module alc_top_sva
(
   input wire logic clock,
   input wire logic srst,
   input alc_pkg::alc_reg_req_type reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic link_pin_i,
   input wire logic link_pin_o,
   input wire logic link_pin_oe,
   input wire logic shared_general_pin_i,
   input wire logic link_busy
);
   import alc_pkg::*;
   logic [7:0] ctrl_q;
   logic [2:0] quiet_q;
   logic [11:0] busy_cnt_q;
   // ----
   // Helper state
   // ----
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         ctrl_q <= 8'h00;
      end
      else if (reg_req.wr && reg_req.addr == ADDR_CTRL)
      begin
         ctrl_q <= reg_req.wdata;
      end
      // Idle checks wait for the line flop to settle after any write
      if (srst || reg_req.wr || link_busy)
      begin
         quiet_q <= 3'h0;
      end
      else if (quiet_q != 3'h4)
      begin
         quiet_q <= quiet_q + 3'h1;
      end
      busy_cnt_q <= link_busy ? busy_cnt_q + 12'h001 : 12'h000;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   sequence go_write_s;
      reg_req.wr && reg_req.addr == ADDR_CTRL && reg_req.wdata[BIT_SEND_GO];
   endsequence
   sequence start_bit_s;
      link_pin_oe && link_pin_o == ctrl_q[BIT_POLARITY];
   endsequence
   // ----
   // Assertions
   // ----
   busy_start_a: assert property (
      !link_busy ##0 go_write_s |-> ##[2:3] link_busy) else $error("busy did not rise");
   start_bit_a: assert property (
      $rose(link_busy) && ctrl_q[BIT_DIRECTION] |-> ##2 start_bit_s [*8])
      else $error("start bit wrong");
   tx_length_a: assert property (
      $fell(link_busy) && ctrl_q[BIT_DIRECTION] |-> busy_cnt_q inside {[12'h18e:12'h196]})
      else $error("transmit length wrong");
   rx_length_a: assert property (
      $fell(link_busy) && !ctrl_q[BIT_DIRECTION] |-> busy_cnt_q inside {[12'h12c:12'hb54]})
      else $error("receive length wrong");
   idle_level_a: assert property (
      quiet_q == 3'h4 |-> link_pin_o == !ctrl_q[BIT_POLARITY]) else $error("idle level wrong");
   two_pin_oe_a: assert property (
      quiet_q == 3'h4 && !ctrl_q[BIT_PIN_COUNT] |-> link_pin_oe) else $error("output released");
   one_pin_idle_a: assert property (
      quiet_q == 3'h4 && ctrl_q[BIT_PIN_COUNT] |-> !link_pin_oe) else $error("pin still driven");
   reserved_read_a: assert property (
      reg_req.rd && reg_req.addr == ADDR_TXD_HI |=> reg_rdata[7:6] == 2'h0)
      else $error("reserved bits set");
   unmapped_read_a: assert property (
      reg_req.rd && reg_req.addr > ADDR_RXD_HI |=> reg_rdata == READ_UNMAPPED)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (
      !reg_req.rd |=> $stable(reg_rdata)) else $error("read data moved");
endmodule
bind alc_top alc_top_sva chk (.clock(clock), .srst(srst), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .link_pin_i(link_pin_i), .link_pin_o(link_pin_o),
   .link_pin_oe(link_pin_oe), .shared_general_pin_i(shared_general_pin_i),
   .link_busy(link_busy));

// [verification/alc_antenna_model.sv]
// Purpose: Behavioural smart antenna on the control link
// Assumes: 25 clocks a bit, start and stop framing, LSB first
// Notes: The line has a pull-up, so a released line reads high
`timescale 1ns/10ps
module alc_antenna_model
(
   input wire logic clock,
   input wire logic line_o,
   input wire logic line_oe,
   input wire logic invert,
   input wire logic ask,
   input wire logic [1:0] reply,
   input wire logic [9:0] code,
   output logic rx_line,
   output logic got,
   output logic [13:0] word
);
   import alc_pkg::*;
   logic [10:0] frame;
   logic [1:0] inv_q;
   // Polarity is taken two clocks late, in step with the device's line flop, so that
   // a polarity change on its own never looks like a start bit
   always @(posedge clock)
   begin
      inv_q <= {inv_q[0], invert};
   end
   // ----
   // Outbound decode and code reply
   // ----
   initial
   begin
      got = 1'b0;
      word = 14'h0000;
      forever
      begin
         @(posedge clock);
         if (line_oe && !(line_o ^ inv_q[1]))
         begin
            repeat (12) @(posedge clock);
            for (int i = 0; i < TX_WORD_W; i++)
            begin
               repeat (25) @(posedge clock);
               word[i] <= line_o ^ inv_q[1];
            end
            repeat (25) @(posedge clock);
            got <= 1'b1;
            @(posedge clock);
            got <= 1'b0;
         end
      end
   end
   initial
   begin
      rx_line = 1'b1;
      forever
      begin
         @(posedge ask);
         // Reply 2 stays silent so the device times out; reply 1 spoils the stop bit
         if (reply != 2'h2)
         begin
            frame = {reply == 2'h0, code};
            repeat (50) @(posedge clock);
            rx_line <= 1'b0;
            for (int i = 0; i < 11; i++)
            begin
               repeat (25) @(posedge clock);
               rx_line <= frame[i];
            end
            repeat (25) @(posedge clock);
            rx_line <= 1'b1;
         end
      end
   end
endmodule

// [verification/testbench.sv]
// Purpose: Self-checking bench for the antenna link control block
// Assumes: Shared general pin already set as an input by the host
// Notes: Reads are checked in order by a monitor process
`timescale 1ns/10ps
module testbench;
   import alc_pkg::*;
   logic clock;
   logic srst;
   alc_reg_req_type req;
   logic [7:0] reg_rdata;
   logic pin_o, pin_oe, busy, ant_line, ask, got, pend;
   logic [1:0] reply;
   logic [9:0] code, last_code;
   logic [13:0] word, w;
   logic [7:0] cfg;
   logic [7:0] rd_q[$];
   logic [13:0] wd_q[$];
   int fails, compares, cyc;
   wire link_in = pin_oe ? pin_o : ant_line;
   alc_top uut (.clock(clock), .srst(srst), .reg_req(req), .reg_rdata(reg_rdata),
      .link_pin_i(link_in), .link_pin_o(pin_o), .link_pin_oe(pin_oe),
      .shared_general_pin_i(ant_line), .link_busy(busy));
   alc_antenna_model ant (.clock(clock), .line_o(pin_o), .line_oe(pin_oe),
      .invert(cfg[BIT_POLARITY]), .ask(ask), .reply(reply), .code(code),
      .rx_line(ant_line), .got(got), .word(word));
   // ----
   // Tasks
   // ----
   task automatic check_rd(input logic [7:0] e, input logic [7:0] v);
      compares++;
      if (v !== e)
      begin
         fails++;
         $display("BAD reg_rdata exp %h got %h", e, v);
      end
   endtask
   task automatic check_word(input logic [13:0] e, input logic [13:0] v);
      compares++;
      if (v !== e)
      begin
         fails++;
         $display("BAD word exp %h got %h", e, v);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      req <= {1'b1, 1'b0, a, d};
      if (a == ADDR_CTRL)
      begin
         cfg <= d;
      end
      @(posedge clock);
      req <= '0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      req <= {1'b0, 1'b1, a, 8'h00};
      rd_q.push_back(e);
      @(posedge clock);
      req <= '0;
   endtask
   // Settle the line level first so the antenna never sees a false start
   task automatic go_cmd(input logic [7:0] c);
      wr_reg(ADDR_CTRL, c & 8'hf7);
      wr_reg(ADDR_CTRL, c);
   endtask
   task automatic wait_idle;
      repeat (4) @(posedge clock);
      while (busy !== 1'b0) @(posedge clock);
   endtask
   task automatic finish_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ----
   // Monitors and stimulus
   // ----
   always @(posedge clock)
   begin
      if (pend)
      begin
         check_rd(rd_q.pop_front(), reg_rdata);
      end
      pend <= req.rd;
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         finish_test();
      end
   end
   always @(posedge got)
   begin
      check_word(wd_q.pop_front(), word);
   end
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial
   begin
      {fails, compares, cyc} = '0;
      {srst, req, ask, reply, code, last_code, cfg, pend} = {1'b1, 50'h0};
      void'($urandom(32'h2549));
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      for (int a = 8'h5f; a <= 8'h64; a++) rd_reg(8'(a), RESET_BYTE);
      wr_reg(ADDR_RXD_HI, 8'hff);
      rd_reg(ADDR_RXD_HI, 8'h03);
      wr_reg(ADDR_RXD_HI, 8'h00);
      wr_reg(ADDR_CTRL, 8'hc0);
      rd_reg(ADDR_CTRL, 8'h40);
      for (int k = 0; k < 4; k++)
      begin
         w = 14'($urandom);
         wr_reg(ADDR_TXD_LO, w[7:0]);
         wr_reg(ADDR_TXD_HI, {2'b11, w[13:8]});
         rd_reg(ADDR_TXD_HI, {2'b00, w[13:8]});
         wd_q.push_back(w);
         go_cmd({3'b000, k[0] ^ k[1], 2'b11, k[1], k[0]});
         wait_idle();
         rd_reg(ADDR_CTRL, {3'b000, k[0] ^ k[1], 1'b0, !(k[0] ^ k[1]), k[1], k[0]});
      end
      for (int k = 0; k < 4; k++)
      begin
         reply <= (k == 3) ? 2'h0 : 2'(k);
         code <= 10'($urandom);
         // Host sets the fault bit itself, so only the start of the receive can clear it
         go_cmd({2'b00, 1'b1, 1'b0, 1'b1, 2'b00, k[0]});
         ask <= 1'b1;
         rd_reg(ADDR_CTRL, {4'b0000, 1'b1, 2'b00, k[0]});
         ask <= 1'b0;
         wait_idle();
         last_code = (reply == 2'h0) ? code : last_code;
         rd_reg(ADDR_RXD_LO, last_code[7:0]);
         rd_reg(ADDR_RXD_HI, {6'h00, last_code[9:8]});
         rd_reg(ADDR_CTRL, {2'b00, reply != 2'h0, 4'b0000, k[0]});
      end
      repeat (4) @(posedge clock);
      finish_test();
   end
endmodule
